// *** src/bspf_map.vh ***
// register map, field positions and timing constants for the self-programming flash control
`ifndef BSPF_MAP_VH
`define BSPF_MAP_VH
`define BSPF_ADDR_W        14
`define BSPF_PAGE_W        7
`define BSPF_NCR_START     14'h3800
`define BSPF_BLS_256       14'h3f00
`define BSPF_BLS_512       14'h3e00
`define BSPF_BLS_1K        14'h3c00
`define BSPF_BLS_2K        14'h3800
`define BSPF_REG_CTRL      4'h0
`define BSPF_REG_ADDR      4'h1
`define BSPF_REG_STAT      4'h2
`define BSPF_REG_CFG       4'h3
`define BSPF_CTRL_START    0
`define BSPF_CTRL_ERASE    1
`define BSPF_CTRL_CLRBUSY  4
`define BSPF_CFG_SZ_LO     0
`define BSPF_CFG_SZ_HI     1
`define BSPF_CFG_BLB0_LO   2
`define BSPF_CFG_BLB0_HI   3
`define BSPF_CFG_BLB1_LO   4
`define BSPF_CFG_BLB1_HI   5
`define BSPF_CFG_RESET     8'h3f
`define BSPF_OP_NS         20000
`define BSPF_CLK_MHZ       40
`define BSPF_OP_CYC        ((`BSPF_OP_NS * `BSPF_CLK_MHZ) / 1000)
`define BSPF_CNT_W         16
`endif

// *** src/bspf_region.v ***
// address classification into sections for the self-programming flash control
`include "bspf_map.vh"
`default_nettype none
module bspf_region (
  input  wire [`BSPF_ADDR_W-1:0] addr_in,
  input  wire [1:0]              boot_size_fuses_in,
  output wire                    in_boot_out,
  output wire                    in_ncr_out
);
  reg [`BSPF_ADDR_W-1:0] boot_start;
  always @* begin
    case (boot_size_fuses_in)
      2'h3:    boot_start = `BSPF_BLS_256;
      2'h2:    boot_start = `BSPF_BLS_512;
      2'h1:    boot_start = `BSPF_BLS_1K;
      default: boot_start = `BSPF_BLS_2K;
    endcase
  end
  // every boot start is at or above the fixed no-concurrent-read start
  assign in_boot_out = (addr_in >= boot_start);
  assign in_ncr_out  = (addr_in >= `BSPF_NCR_START);
endmodule
`default_nettype wire

// *** src/bspf_timer.v ***
// programming duration counter
`include "bspf_map.vh"
`default_nettype none
module bspf_timer (
  input  wire clock_in,
  input  wire rst_in,
  input  wire ce_in,
  input  wire start_in,
  output wire done_out
);
  localparam [`BSPF_CNT_W-1:0] OP_CYC = `BSPF_OP_CYC;
  reg [`BSPF_CNT_W-1:0] count;
  reg                   run;
  always @(posedge clock_in) begin
    if (rst_in) begin
      count <= {`BSPF_CNT_W{1'b0}};
      run   <= 1'b0;
    end else if (ce_in) begin
      if (start_in) begin
        count <= OP_CYC - 16'h0001;
        run   <= 1'b1;
      end else if (run) begin
        if (count == {`BSPF_CNT_W{1'b0}})
          run <= 1'b0;
        else
          count <= count - 16'h0001;
      end
    end
  end
  assign done_out = run && (count == {`BSPF_CNT_W{1'b0}});
endmodule
`default_nettype wire

// *** src/bspf_ctrl.v ***
// self-programming flash control: section checks, lock bits, stall and busy flag
// Operation
// - programming starts only if the store-program instr was fetched from the boot section
// - store-program instr fetched from application section starts no programming; it only sets the refused flag
// - from the boot section any flash address may be targeted
// - boot size fuses set the section boundary; each section has lock bits
// - lock set 0 guards the application section
// - lock set 1 guards the boot loader section
// - concurrent-read split is fixed, independent of boot size fuses
// - programming in concurrent-read section leaves other section readable
// - programming in no-concurrent-read section stalls the core until the done cycle, when the stall drops
// - concurrent-read section returns no valid code during any programming
// - boot loader section always lies inside no-concurrent-read section
// - busy flag reads one while concurrent-read section is blocked
// - busy flag holds after completion until software clears it
// - erase and write act on whole pages; reads ignore pages
`include "bspf_map.vh"
`default_nettype none
module bspf_ctrl (
  input  wire                    clock_in,
  input  wire                    rst_in,
  input  wire                    ce_in,
  input  wire                    wb_cyc_in,
  input  wire                    wb_stb_in,
  input  wire                    wb_we_in,
  input  wire [3:0]              wb_adr_in,
  input  wire [3:0]              wb_sel_in,
  input  wire [31:0]             wb_dat_in,
  output reg  [31:0]             wb_dat_out,
  output wire                    wb_ack_out,
  input  wire [`BSPF_ADDR_W-1:0] fetch_pc_in,
  input  wire [`BSPF_ADDR_W-1:0] read_addr_in,
  input  wire                    read_req_in,
  output wire                    read_valid_out,
  output wire                    core_stall_out,
  output reg                     prog_active_out,
  output reg                     prog_erase_out,
  output reg  [`BSPF_ADDR_W-1:0] prog_page_out,
  output wire                    prog_done_out
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_PROG = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg  [2:0]              state;
  reg  [2:0]              next_state;
  reg  [7:0]              cfg;
  reg  [`BSPF_ADDR_W-1:0] target;
  reg                     busy;
  reg                     stall;
  reg                     ack;
  reg                     refused;
  wire                    pc_boot;
  wire                    pc_ncr;
  wire                    tgt_boot;
  wire                    tgt_ncr;
  wire                    rd_boot;
  wire                    rd_ncr;
  wire                    done;
  wire                    wr;
  wire                    start_req;
  wire                    clr_req;
  wire                    lock_app;
  wire                    lock_boot;
  wire                    allowed;
  wire                    go;

  // the boundary moves with the fuses, the concurrent-read split does not
  bspf_region u_pc (
    .addr_in            (fetch_pc_in),
    .boot_size_fuses_in (cfg[`BSPF_CFG_SZ_HI:`BSPF_CFG_SZ_LO]),
    .in_boot_out        (pc_boot),
    .in_ncr_out         (pc_ncr)
  );
  bspf_region u_tgt (
    .addr_in            (target),
    .boot_size_fuses_in (cfg[`BSPF_CFG_SZ_HI:`BSPF_CFG_SZ_LO]),
    .in_boot_out        (tgt_boot),
    .in_ncr_out         (tgt_ncr)
  );
  bspf_region u_rd (
    .addr_in            (read_addr_in),
    .boot_size_fuses_in (cfg[`BSPF_CFG_SZ_HI:`BSPF_CFG_SZ_LO]),
    .in_boot_out        (rd_boot),
    .in_ncr_out         (rd_ncr)
  );
  bspf_timer u_timer (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .ce_in    (ce_in),
    .start_in (go),
    .done_out (done)
  );

  wire unused_ok       = pc_ncr | rd_boot;
  wire unused_ok_dummy = 1'b0 & unused_ok;

  assign wr        = wb_cyc_in && wb_stb_in && wb_we_in && !ack && wb_sel_in[0];
  assign start_req = wr && (wb_adr_in == `BSPF_REG_CTRL) && wb_dat_in[`BSPF_CTRL_START];
  assign clr_req   = wr && (wb_adr_in == `BSPF_REG_CTRL) && wb_dat_in[`BSPF_CTRL_CLRBUSY];
  // lock bits programmed (0) on the low bit forbid store-program writes
  assign lock_app  = !cfg[`BSPF_CFG_BLB0_LO];
  assign lock_boot = !cfg[`BSPF_CFG_BLB1_LO];
  assign allowed   = pc_boot && (tgt_boot ? !lock_boot : !lock_app);
  assign go        = ce_in && start_req && (state == ST_IDLE) && allowed;

  always @* begin
    case (state)
      ST_IDLE: next_state = go ? ST_PROG : ST_IDLE;
      ST_PROG: next_state = done ? ST_DONE : ST_PROG;
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clock_in) begin
    if (rst_in) begin
      state           <= ST_IDLE;
      cfg             <= `BSPF_CFG_RESET;
      target          <= {`BSPF_ADDR_W{1'b0}};
      busy            <= 1'b0;
      stall           <= 1'b0;
      ack             <= 1'b0;
      refused         <= 1'b0;
      wb_dat_out      <= 32'h00000000;
      prog_active_out <= 1'b0;
      prog_erase_out  <= 1'b0;
      prog_page_out   <= {`BSPF_ADDR_W{1'b0}};
    end else if (ce_in) begin
      state <= next_state;
      ack   <= wb_cyc_in && wb_stb_in && !ack;
      if (wr && wb_adr_in == `BSPF_REG_ADDR && state == ST_IDLE)
        target <= wb_dat_in[`BSPF_ADDR_W-1:0];
      if (wr && wb_adr_in == `BSPF_REG_CFG && state == ST_IDLE)
        cfg <= wb_dat_in[7:0];
      if (start_req && state == ST_IDLE)
        refused <= !allowed;
      if (go) begin
        // page-aligned address: the whole page is erased or written
        prog_page_out   <= {target[`BSPF_ADDR_W-1:`BSPF_PAGE_W],
                            {`BSPF_PAGE_W{1'b0}}};
        prog_erase_out  <= wb_dat_in[`BSPF_CTRL_ERASE];
        prog_active_out <= 1'b1;
        stall           <= tgt_ncr;
      end else if (done) begin
        prog_active_out <= 1'b0;
        stall           <= 1'b0;
      end
      // set wins over clear, and no clear while programming runs
      if (go)
        busy <= 1'b1;
      else if (clr_req && state == ST_IDLE && !prog_active_out)
        busy <= 1'b0;
      if (wb_cyc_in && wb_stb_in && !wb_we_in && !ack) begin
        case (wb_adr_in)
          `BSPF_REG_CTRL: wb_dat_out <= {26'h0000000, busy, 4'h0, prog_active_out};
          `BSPF_REG_ADDR: wb_dat_out <= {18'h00000, target};
          `BSPF_REG_STAT: wb_dat_out <= {29'h00000000, refused, stall, busy};
          `BSPF_REG_CFG:  wb_dat_out <= {24'h000000, cfg};
          default:        wb_dat_out <= 32'h00000000;
        endcase
      end
    end
  end

  assign wb_ack_out     = ack;
  assign prog_done_out  = done && ce_in;
  // stall drops combinationally with done so fetch resumes that very cycle
  assign core_stall_out = stall && !done;
  // reads of the no-concurrent-read section stay served unless core_stall_out is high; blocked region gets no valid code
  assign read_valid_out = read_req_in && (rd_ncr || !busy) && !core_stall_out
                          && !unused_ok_dummy;
endmodule
`default_nettype wire

// *** verif/bspf_core_model.sv ***
// processor core model issuing flash reads
`default_nettype none
module bspf_core_model (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        stall_in,
  output var  logic [13:0] read_addr_out,
  output var  logic        read_req_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // a halted core issues no reads; otherwise it alternates sections each cycle
  always @(posedge clock_in) begin
    read_req_out  <= !rst_in && !stall_in;
    read_addr_out <= (rst_in || read_addr_out[13]) ? 14'h1000 : 14'h3900;
  end
endmodule
`default_nettype wire

// *** verif/bspf_ctrl_asserts.sv ***
// port checks for the self-programming flash control
`default_nettype none
module bspf_ctrl_asserts (
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire logic [13:0] fetch_pc_in,
  input wire logic [13:0] read_addr_in,
  input wire logic        read_req_in,
  input wire logic        read_valid_out,
  input wire logic        core_stall_out,
  input wire logic        prog_active_out,
  input wire logic [13:0] prog_page_out,
  input wire logic        prog_done_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic [9:0] run_len;
  logic       ncr;
  assign ncr = prog_page_out >= 14'h3800;
  always @(posedge clock_in) begin
    run_len <= (rst_in || !prog_active_out) ? 10'h000 : run_len + 10'h001;
  end
  property p_src; $rose(prog_active_out) |-> $past(fetch_pc_in) >= 14'h3800; endproperty
  a_src: assert property (p_src) else $error("start from app");
  property p_page; prog_active_out |-> prog_page_out[6:0] == 7'h00; endproperty
  a_page: assert property (p_page) else $error("page unaligned");
  property p_hold; prog_active_out && !prog_done_out |=> $stable(prog_page_out); endproperty
  a_hold: assert property (p_hold) else $error("page moved");
  property p_len; prog_done_out |-> prog_active_out && run_len == 10'h31f; endproperty
  a_len: assert property (p_len) else $error("op length");
  property p_stall; prog_active_out && !prog_done_out |-> core_stall_out == ncr; endproperty
  a_stall: assert property (p_stall) else $error("stall vs section");
  property p_free; prog_done_out |=> !core_stall_out [*2]; endproperty
  a_free: assert property (p_free) else $error("stall kept");
  property p_cr; prog_active_out && read_req_in && !read_addr_in[13] |-> !read_valid_out;
  endproperty
  a_cr: assert property (p_cr) else $error("read during op");
  property p_ncr; prog_active_out && !ncr && read_req_in && read_addr_in >= 14'h3800
    |-> read_valid_out; endproperty
  a_ncr: assert property (p_ncr) else $error("ncr read blocked");
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// self-checking bench for the self-programming flash control
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1;
  logic        wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
  logic [3:0]  wb_adr_in = 4'h0, wb_sel_in = 4'hf;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out, rd;
  logic [13:0] fetch_pc_in = 14'h3f00, read_addr_in, prog_page_out;
  logic        wb_ack_out, read_req_in, read_valid_out, core_stall_out;
  logic        prog_active_out, prog_erase_out, prog_done_out;
  int          fail_count = 0, n_tests = 0, cycles = 0;
  bspf_ctrl DUT (.*);
  bspf_core_model core (.clock_in(clock_in), .rst_in(rst_in), .stall_in(core_stall_out),
    .read_addr_out(read_addr_in), .read_req_out(read_req_in));
  initial forever #12.5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= a;
    wb_dat_in <= d;
    do @(posedge clock_in); while (wb_ack_out !== 1'b1);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask
  task automatic cr_slot;
    @(negedge clock_in);
    if (read_addr_in[13]) @(negedge clock_in);
  endtask
  task automatic t_refused(input logic [7:0] cfg, input logic [13:0] pc, tgt);
    fetch_pc_in <= pc;
    wb(1'b1, 4'h3, {24'h0, cfg});
    wb(1'b1, 4'h1, {18'h0, tgt});
    wb(1'b1, 4'h0, 32'h1);
    chk(prog_active_out, 1'b0);
    wb(1'b0, 4'h2, 32'h0);
    chk(rd[2], 1'b1);
    $display("refused start test done");
  endtask
  // the erase flag doubles as the stall expectation so both commands are used
  task automatic t_prog(input logic [7:0] cfg, input logic [13:0] pc, tgt, input logic ncr);
    fetch_pc_in <= pc;
    wb(1'b1, 4'h3, {24'h0, cfg});
    wb(1'b1, 4'h1, {18'h0, tgt});
    wb(1'b1, 4'h0, {30'h0, ncr, 1'b1});
    @(negedge clock_in);
    chk(prog_erase_out, ncr);
    chk(prog_page_out, {tgt[13:7], 7'h00});
    chk(core_stall_out, ncr);
    do @(negedge clock_in); while (prog_done_out !== 1'b1);
    cr_slot();
    chk(core_stall_out, 1'b0);
    chk(read_valid_out, 1'b0);
    wb(1'b0, 4'h2, 32'h0);
    chk(rd[0], 1'b1);
    wb(1'b1, 4'h0, 32'h10);
    cr_slot();
    chk(read_valid_out, 1'b1);
    $display("programming test done");
  endtask
  initial begin
    repeat (10) @(posedge clock_in);
    rst_in <= 1'b0;
    wb(1'b0, 4'h3, 32'h0);
    chk(rd, 32'h3f);
    wb(1'b0, 4'h7, 32'h0);
    chk(rd, 32'h0);
    t_refused(8'h3f, 14'h0100, 14'h1000);
    t_refused(8'h3b, 14'h3f00, 14'h1000);
    t_refused(8'h2f, 14'h3f00, 14'h3f80);
    t_prog(8'h3f, 14'h3f00, 14'h1005, 1'b0);
    t_prog(8'h3f, 14'h3f00, 14'h3f85, 1'b1);
    t_prog(8'h3c, 14'h3800, 14'h1000, 1'b0);
    give_verdict();
  end
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
endmodule
bind bspf_ctrl bspf_ctrl_asserts u_chk (.*);
`default_nettype wire
